// ### shared/bsea_pkg.sv
// bsea_pkg: constants for the bit-serial nonvolatile array access block
// assumes nothing beyond a SystemVerilog compiler
package bsea_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] BSEA_SELECT_ADDR = 8'h0e;
  localparam logic [7:0] BSEA_STATUS_ADDR = 8'h0f;
  localparam logic [7:0] BSEA_SELECT_RESET = 8'h00;
  // ************************************************************
  // status/control bit positions
  // ************************************************************
  localparam int BSEA_FIRST_COL_BIT = 0;
  localparam int BSEA_UNUSED_BIT = 1;
  localparam int BSEA_PUMP_CLK_BIT = 2;
  localparam int BSEA_PUMP_EN_BIT = 3;
  localparam int BSEA_BULK_BIT = 4;
  localparam int BSEA_PROGRAM_BIT = 5;
  localparam int BSEA_ROW_ERASE_BIT = 6;
  localparam int BSEA_DATA_BIT = 7;
  // ************************************************************
  // array geometry and timing
  // ************************************************************
  localparam int BSEA_ROWS = 16;
  localparam int BSEA_COLS = 8;
  localparam int BSEA_CLK_MHZ = 100;
  localparam int BSEA_PUMP_START_US = 10;
  localparam int BSEA_PUMP_START_CYC = BSEA_PUMP_START_US * BSEA_CLK_MHZ;
  localparam int BSEA_RING_DIV = 4;
  localparam logic [BSEA_COLS-1:0] BSEA_ERASED_ROW = 8'h00;
  typedef enum logic [1:0] {
    BSEA_PUMP_OFF,
    BSEA_PUMP_START,
    BSEA_PUMP_ON
  } bsea_pump_type;
endpackage

// ### rtl/bsea_decoder.sv
// bsea_decoder: one-hot decoder for a row or column index
// assumes a binary index driven from a register
`timescale 1ns/1ps
`default_nettype none
module bsea_decoder #(
  parameter int WIDTH = 3
) (
  // index in
  input wire logic [WIDTH-1:0] index,
  // one-hot out
  output logic [(1<<WIDTH)-1:0] oneHot
);
  always_comb begin
    oneHot = '0;
    oneHot[index] = 1'b1;
  end
endmodule
`default_nettype wire

// ### rtl/bsea_array.sv
// bsea_array: 16 x 8 nonvolatile store with one shared sense output
// assumes row and column selects are one-hot
`timescale 1ns/1ps
`default_nettype none
module bsea_array
  import bsea_pkg::*;
(
  // clock
  input wire logic core_clk,
  // selects
  input wire logic [BSEA_ROWS-1:0] rowSel,
  input wire logic [BSEA_COLS-1:0] colSel,
  // high-voltage actions, already gated by the pump
  input wire logic programBit,
  input wire logic eraseRow,
  input wire logic eraseAll,
  // sense output, registered
  output logic senseData
);
  // contents survive reset: the array is nonvolatile
  logic [BSEA_COLS-1:0] cellsReg [BSEA_ROWS];
  logic senseNext;

  always_ff @(posedge core_clk) begin
    for (int r = 0; r < BSEA_ROWS; r++) begin
      if (eraseAll || (eraseRow && rowSel[r])) begin
        cellsReg[r] <= BSEA_ERASED_ROW;
      end else if (programBit && rowSel[r]) begin
        cellsReg[r] <= cellsReg[r] | colSel;
      end
    end
  end

  always_comb begin
    senseNext = 1'b0;
    for (int r = 0; r < BSEA_ROWS; r++) begin
      if (rowSel[r]) begin
        senseNext = |(cellsReg[r] & colSel);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    senseData <= senseNext;
  end
endmodule
`default_nettype wire

// ### rtl/bsea_top.sv
// bsea_top: register access to a bit-serial nonvolatile array
// assumes a single-cycle register port; read data one cycle later
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - 128-bit array, 16 rows of 8, one bit routed to a sense amp
// RULE2 - bit select register at 0x0e, read/write, cleared by reset
// RULE3 - bits 6:3 pick the row, bits 2:0 the column, separate decoders
// RULE4 - top select bit is plain storage, no part in decoding
// RULE5 - status/control at 0x0f, five user bits, bit 1 reads zero
// RULE6 - reset clears controls; first-column flag set, data shows bit 0
// RULE7 - first-column flag is one exactly when column zero is selected
// RULE8 - pump clock source bit read/write; set bus clock, clear ring osc
// RULE9 - software keeps ring oscillator selected below 1 MHz bus clock
// RULE10 - pump active only with enable plus a program or erase bit; here, once started, it stays active on program/erase bits alone
// RULE11 - pump runs until program/erase bits clear; full stop needs all clear
// RULE12 - sensed data undefined while pump enable is set
// RULE13 - pump enable read/write, cleared in reset
// RULE14 - software always enables pump to program or erase
// RULE15 - data bit read-only, shows sense amp for selected bit
// RULE16 - program with pump active writes one to the addressed bit
// RULE17 - row erase with pump active clears the addressed row
// RULE18 - bulk erase clears everything; row plus bulk also erases all
// RULE19 - status/control bit positions fixed as constants
// RULE20 - pump startup is a cycle count before array effects
module bsea_top
  import bsea_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // pump observation
  output logic pumpActive,
  output logic pumpClock
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] selectReg;
  logic pumpClkSelReg;
  logic pumpEnReg;
  logic programReg;
  logic rowEraseReg;
  logic bulkReg;
  logic [7:0] statusView;
  logic [7:0] rdNext;
  logic firstColumnFlag;
  logic senseData;
  logic anyAction;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      selectReg <= BSEA_SELECT_RESET; // RULE2
    end else if (regWrite && regAddr == BSEA_SELECT_ADDR) begin
      selectReg <= regWrData; // RULE2 RULE4
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pumpClkSelReg <= 1'b0; // RULE8
      pumpEnReg <= 1'b0; // RULE13
      programReg <= 1'b0; // RULE6
      rowEraseReg <= 1'b0;
      bulkReg <= 1'b0;
    end else if (regWrite && regAddr == BSEA_STATUS_ADDR) begin
      pumpClkSelReg <= regWrData[BSEA_PUMP_CLK_BIT]; // RULE8 RULE19
      pumpEnReg <= regWrData[BSEA_PUMP_EN_BIT]; // RULE13
      programReg <= regWrData[BSEA_PROGRAM_BIT];
      rowEraseReg <= regWrData[BSEA_ROW_ERASE_BIT];
      bulkReg <= regWrData[BSEA_BULK_BIT];
    end
  end

  // ************************************************************
  // decoders and array
  // ************************************************************
  logic [BSEA_ROWS-1:0] rowSel;
  logic [BSEA_COLS-1:0] colSel;

  bsea_decoder #(.WIDTH(4)) rowDecoder (
    .index(selectReg[6:3]), // RULE3
    .oneHot(rowSel)
  );

  bsea_decoder #(.WIDTH(3)) colDecoder (
    .index(selectReg[2:0]), // RULE3
    .oneHot(colSel)
  );

  assign firstColumnFlag = colSel[0]; // RULE7

  // ************************************************************
  // charge pump
  // ************************************************************
  // ring oscillator stands in as a divided enable of the one clock
  logic [7:0] ringCntReg;
  logic ringTick;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ringCntReg <= 8'h00;
    end else if (ringCntReg == 8'(BSEA_RING_DIV - 1)) begin
      ringCntReg <= 8'h00;
    end else begin
      ringCntReg <= ringCntReg + 8'h01;
    end
  end
  assign ringTick = (ringCntReg == 8'h00);

  bsea_pump_type pumpStateReg;
  logic [15:0] startCntReg;
  assign anyAction = programReg | rowEraseReg | bulkReg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pumpStateReg <= BSEA_PUMP_OFF;
      startCntReg <= 16'h0000;
    end else begin
      unique case (pumpStateReg)
        BSEA_PUMP_OFF: begin
          if (pumpEnReg && anyAction) begin
            pumpStateReg <= BSEA_PUMP_START; // RULE10
            startCntReg <= 16'h0000;
          end
        end
        BSEA_PUMP_START: begin
          if (!anyAction) begin
            pumpStateReg <= BSEA_PUMP_OFF;
          end else if (startCntReg == 16'(BSEA_PUMP_START_CYC - 1)) begin
            pumpStateReg <= BSEA_PUMP_ON; // RULE20
          end else begin
            startCntReg <= startCntReg + 16'h0001;
          end
        end
        BSEA_PUMP_ON: begin
          // keeps running on action bits alone; stops once all are clear
          if (!anyAction) begin
            pumpStateReg <= BSEA_PUMP_OFF; // RULE11
          end
        end
      endcase
    end
  end

  assign pumpActive = (pumpStateReg != BSEA_PUMP_OFF); // RULE10
  assign pumpClock = pumpActive & (pumpClkSelReg ? 1'b1 : ringTick); // RULE8

  bsea_array array (
    .core_clk(core_clk),
    .rowSel(rowSel),
    .colSel(colSel), // RULE1
    .programBit(pumpStateReg == BSEA_PUMP_ON && programReg), // RULE16
    .eraseRow(pumpStateReg == BSEA_PUMP_ON && rowEraseReg), // RULE17
    .eraseAll(pumpStateReg == BSEA_PUMP_ON && bulkReg), // RULE18
    .senseData(senseData) // RULE15
  );

  // ************************************************************
  // read path
  // ************************************************************
  // data forced to zero while pump enabled: value is undefined there
  always_comb begin
    statusView = 8'h00;
    statusView[BSEA_FIRST_COL_BIT] = firstColumnFlag; // RULE6
    statusView[BSEA_UNUSED_BIT] = 1'b0; // RULE5
    statusView[BSEA_PUMP_CLK_BIT] = pumpClkSelReg;
    statusView[BSEA_PUMP_EN_BIT] = pumpEnReg;
    statusView[BSEA_BULK_BIT] = bulkReg;
    statusView[BSEA_PROGRAM_BIT] = programReg;
    statusView[BSEA_ROW_ERASE_BIT] = rowEraseReg;
    statusView[BSEA_DATA_BIT] = senseData & ~pumpEnReg; // RULE12 RULE15
  end

  always_comb begin
    unique case (regAddr)
      BSEA_SELECT_ADDR: rdNext = selectReg;
      BSEA_STATUS_ADDR: rdNext = statusView; // RULE5
      default: rdNext = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= rdNext;
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### verification/bsea_checker.sv
// bsea_checker: port assertions for bsea_top
// assumes the one-cycle register port and read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module bsea_checker
  import bsea_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // pump
  input wire logic pumpActive,
  input wire logic pumpClock
);
  logic [7:0] sel_reg;
  logic [7:0] ctl_reg;
  // copies of software writes, so reads can be predicted
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sel_reg <= 8'h00;
    end else if (regWrite && regAddr == BSEA_SELECT_ADDR) begin
      sel_reg <= regWrData;
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl_reg <= 8'h00;
    end else if (regWrite && regAddr == BSEA_STATUS_ADDR) begin
      ctl_reg <= regWrData & 8'h7c;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_sel_back: assert property (
    $past(regRead) && $past(regAddr) == BSEA_SELECT_ADDR
    |-> regRdData == $past(sel_reg)) else $error("select readback");
  chk_first_col: assert property (
    $past(regRead) && $past(regAddr) == BSEA_STATUS_ADDR
    |-> regRdData[0] == ($past(sel_reg[2:0]) == 3'h0))
    else $error("first column flag");
  chk_unused_bit: assert property (
    $past(regRead) && $past(regAddr) == BSEA_STATUS_ADDR
    |-> !regRdData[1]) else $error("unused bit set");
  chk_ctl_back: assert property (
    $past(regRead) && $past(regAddr) == BSEA_STATUS_ADDR
    |-> regRdData[6:2] == $past(ctl_reg[6:2])) else $error("ctl readback");
  chk_data_mask: assert property (
    $past(regRead) && $past(regAddr) == BSEA_STATUS_ADDR && $past(ctl_reg[3])
    |-> !regRdData[7]) else $error("data not masked");
  chk_pump_start: assert property (
    $rose(pumpActive) |-> ctl_reg[3] && ctl_reg[6:4] != 3'h0)
    else $error("pump started unasked");
  chk_pump_stop: assert property (
    (ctl_reg[6:4] == 3'h0) [*3] |-> !pumpActive) else $error("pump left on");
  chk_clk_gated: assert property (
    !pumpActive |-> !pumpClock) else $error("pump clock while idle");
  chk_bus_clk: assert property (
    pumpActive && ctl_reg[2] |-> pumpClock) else $error("bus clock missing");
  chk_ring_clk: assert property (
    pumpClock && !ctl_reg[2] |=> !pumpClock [*3]) else $error("ring rate");
endmodule
bind bsea_top bsea_checker i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .pumpActive(pumpActive),
  .pumpClock(pumpClock));
`default_nettype wire

// ### verification/tb_bsea_top.sv
// tb_bsea_top: register-level tests of bsea_top
// assumes bsea_checker is bound in; array starts unknown
`timescale 1ns/1ps
`default_nettype none
module tb_bsea_top
  import bsea_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdData;
  logic pumpActive;
  logic pumpClock;
  int errCount = 0;
  int checked = 0;
  bsea_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .pumpActive(pumpActive),
    .pumpClock(pumpClock));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // idle cycles first: sense data lags a select write
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] m);
    repeat (2) @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e & m, regRdData & m);
  endtask
  task automatic pump(input logic [7:0] c);
    wr(8'h0f, c);
    repeat (BSEA_PUMP_START_CYC + 20) @(posedge core_clk);
    chk("pump on", 8'h01, {7'h00, pumpActive});
    wr(8'h0f, c & 8'hf7);
    chk("pump kept", 8'h01, {7'h00, pumpActive});
    wr(8'h0f, 8'h00);
    repeat (3) @(posedge core_clk);
    chk("pump off", 8'h00, {7'h00, pumpActive});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errCount++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h0e, 8'h00, 8'hff);
    rd(8'h0f, 8'h01, 8'h7f);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00, 8'hff);
    $display("test reset done");
    pump(8'h58);
    rd(8'h0f, 8'h01, 8'hff);
    wr(8'h0e, 8'h7f);
    rd(8'h0f, 8'h00, 8'hff);
    $display("test erase done");
    wr(8'h0e, 8'h2b);
    pump(8'h2c);
    wr(8'h0e, 8'hab);
    rd(8'h0e, 8'hab, 8'hff);
    rd(8'h0f, 8'h80, 8'hff);
    wr(8'h0e, 8'h28);
    rd(8'h0f, 8'h01, 8'hff);
    $display("test program done");
    // read-only bits and bit 1 must ignore the write
    wr(8'h0e, 8'h2b);
    wr(8'h0f, 8'h8b);
    rd(8'h0f, 8'h08, 8'hff);
    chk("pump idle", 8'h00, {7'h00, pumpActive});
    wr(8'h0f, 8'h00);
    wr(8'h0e, 8'h28);
    pump(8'h48);
    wr(8'h0e, 8'h2b);
    rd(8'h0f, 8'h00, 8'hff);
    $display("test row erase done");
    // mid-run reset must clear pump enable and clock source again
    wr(8'h0f, 8'h0c);
    wr(8'h0e, 8'h2b);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h0e, 8'h00, 8'hff);
    rd(8'h0f, 8'h01, 8'h7f);
    $display("test second reset done");
    finish_test;
  end
endmodule
`default_nettype wire
